// ===== windowed_watchdog.sv
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "wwdt_consts.svh"

// Contract
// - the enable bit can only be set by software, and once set and fed the counter runs for good.
// - once the counter is not above a nonzero warning value the warning is raised two ticks later.
// - every completed feed that the window accepts reloads the counter from the timeout reload register.
// - a reload value written below 0xFF is stored as 0xFF.
// - the counter decrements once every four watchdog tick clock periods.
// - with protection on, changing the reload value before the running counter is below warning and window is a timeout.
// - a feed while the running counter is above the window value is a watchdog event and is not accepted.
// - the counter is 24 bits and a window of 0xFFFFFF never rejects a feed.
// - a feed is the first word then the second word written back to back to the feed register.
// - a timeout resets the chip only when reset on timeout is enabled.
// - a timeout sets a sticky timeout flag that software can read and clear.
// - the warning sets a sticky warning flag.
// - the oscillator lock bit, once set, holds until reset and blocks oscillator power down.
// - a warning value of zero never produces a warning.
module windowed_watchdog #(
	parameter logic [31:0] FEED_FIRST_WORD = 32'h0000_00AA,
	parameter logic [31:0] FEED_SECOND_WORD = 32'h0000_0055
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic watchdog_tick_clock,
	output logic irq,
	output logic chip_reset_req,
	output logic osc_lock
);

	localparam wwdt_pkg::state_s RST = '{
		hreadyout: 1'b1,
		hresp: 1'b0,
		hrdata: 32'h0000_0000,
		wr_pend: 1'b0,
		wr_addr: 8'h00,
		en: 1'b0,
		rst_en: 1'b0,
		prot: 1'b0,
		lock: 1'b0,
		running: 1'b0,
		reload: `WWDT_RELOAD_RST,
		cnt: `WWDT_RELOAD_RST,
		win: `WWDT_WIN_RST,
		warn: `WWDT_WARN_RST,
		stat: 2'h0,
		mask: 2'h0,
		pre: 2'h0,
		tick_d: 1'b0,
		warn_pend: 1'b0,
		feed: wwdt_pkg::FEED_IDLE,
		irq: 1'b0,
		chip_rst: 1'b0
	};

	wwdt_pkg::state_s r;
	wwdt_pkg::state_s n;

	function automatic logic [31:0] read_reg(input logic [7:0] a, input wwdt_pkg::state_s s);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			`WWDT_OFS_MODE: begin
				d[`WWDT_MODE_EN] = s.en;
				d[`WWDT_MODE_RST] = s.rst_en;
				d[`WWDT_MODE_PROT] = s.prot;
				d[`WWDT_MODE_LOCK] = s.lock;
			end
			`WWDT_OFS_RELOAD: d[`WWDT_CNT_W-1:0] = s.reload;
			`WWDT_OFS_COUNT: d[`WWDT_CNT_W-1:0] = s.cnt;
			`WWDT_OFS_WARN: d[`WWDT_CNT_W-1:0] = s.warn;
			`WWDT_OFS_WIN: d[`WWDT_CNT_W-1:0] = s.win;
			`WWDT_OFS_STAT: d[1:0] = s.stat;
			`WWDT_OFS_MASK: d[1:0] = s.mask;
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	logic tick_edge;
	logic tof_set;
	logic warn_set;
	logic feed_done;
	logic [1:0] stat_clr;
	logic addr_ok;

	always_comb begin
		n = r;
		n.hreadyout = 1'b1;
		n.hresp = 1'b0;
		n.chip_rst = 1'b0;
		tof_set = 1'b0;
		warn_set = 1'b0;
		feed_done = 1'b0;
		stat_clr = 2'h0;
		// tick clock is taken as synchronous; rising edge marks one tick
		tick_edge = watchdog_tick_clock & ~r.tick_d;
		n.tick_d = watchdog_tick_clock;

		if (tick_edge) begin
			n.pre = 2'(r.pre + `WWDT_PRE_ONE);
			if (r.running) begin
				warn_set = r.warn_pend;
				n.warn_pend = (r.warn != `WWDT_CNT_ZERO) && (r.cnt <= r.warn);
				if (r.pre == `WWDT_PRE_LAST) begin
					if (r.cnt == `WWDT_CNT_ZERO) begin
						tof_set = 1'b1;
						n.cnt = r.reload;
					end else begin
						n.cnt = 24'(r.cnt - `WWDT_CNT_ONE);
					end
				end
			end
		end

		// data phase of a write
		if (r.wr_pend) begin
			if (r.wr_addr != `WWDT_OFS_FEED) begin
				n.feed = wwdt_pkg::FEED_IDLE;
			end
			unique case (r.wr_addr)
				`WWDT_OFS_MODE: begin
					n.en = r.en | hwdata[`WWDT_MODE_EN];
					n.rst_en = hwdata[`WWDT_MODE_RST];
					n.prot = hwdata[`WWDT_MODE_PROT];
					n.lock = r.lock | hwdata[`WWDT_MODE_LOCK];
				end
				`WWDT_OFS_RELOAD: begin
					if (r.prot && r.running && !((r.cnt < r.warn) && (r.cnt < r.win))) begin
						tof_set = 1'b1;
					end else if (hwdata[`WWDT_CNT_W-1:0] < `WWDT_RELOAD_MIN) begin
						n.reload = `WWDT_RELOAD_MIN;
					end else begin
						n.reload = hwdata[`WWDT_CNT_W-1:0];
					end
				end
				`WWDT_OFS_FEED: begin
					unique case (r.feed)
						wwdt_pkg::FEED_IDLE: begin
							if (hwdata == FEED_FIRST_WORD) begin
								n.feed = wwdt_pkg::FEED_ARMED;
							end
						end
						wwdt_pkg::FEED_ARMED: begin
							if (hwdata == FEED_SECOND_WORD) begin
								feed_done = 1'b1;
								n.feed = wwdt_pkg::FEED_IDLE;
							end else if (hwdata != FEED_FIRST_WORD) begin
								n.feed = wwdt_pkg::FEED_IDLE;
							end
						end
					endcase
				end
				`WWDT_OFS_WARN: n.warn = hwdata[`WWDT_CNT_W-1:0];
				`WWDT_OFS_WIN: n.win = hwdata[`WWDT_CNT_W-1:0];
				`WWDT_OFS_STAT: stat_clr = hwdata[1:0];
				`WWDT_OFS_MASK: n.mask = hwdata[1:0];
				default: begin
				end
			endcase
		end

		if (feed_done) begin
			if (r.running && (r.cnt > r.win)) begin
				tof_set = 1'b1;
			end else begin
				n.cnt = r.reload;
				n.pre = 2'h0;
				n.warn_pend = 1'b0;
				n.running = r.running | r.en;
			end
		end

		n.stat[`WWDT_STAT_TOF] = (r.stat[`WWDT_STAT_TOF] & ~stat_clr[`WWDT_STAT_TOF]) | tof_set;
		n.stat[`WWDT_STAT_WARN] = (r.stat[`WWDT_STAT_WARN] & ~stat_clr[`WWDT_STAT_WARN]) | warn_set;
		n.chip_rst = tof_set & r.rst_en;
		n.irq = |(n.stat & n.mask);

		// address phase
		addr_ok = hsel && htrans[1] && hready;
		n.wr_pend = addr_ok && hwrite;
		n.wr_addr = haddr[7:0];
		// read data reflects a write that completes in this same cycle
		n.hrdata = (addr_ok && !hwrite) ? read_reg(haddr[7:0], n) : 32'h0000_0000;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			r <= RST;
		end else begin
			r <= n;
		end
	end

	assign hreadyout = r.hreadyout;
	assign hresp = r.hresp;
	assign hrdata = r.hrdata;
	assign irq = r.irq;
	assign chip_reset_req = r.chip_rst;
	assign osc_lock = r.lock;

endmodule

// ===== windowed_watchdog_tb.sv
`timescale 1ns/1ps
module windowed_watchdog_tb;
	logic clk = 1'b0, nrst = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, t0;
	logic [1:0] htrans = 2'h0, div = 2'h0;
	logic hrdy, irq, chip_reset_req, osc_lock;
	int bad_count = 0, n_tests = 0;
	windowed_watchdog windowed_watchdog_inst (.clk, .nrst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata, .watchdog_tick_clock(div[1]), .irq,
		.chip_reset_req, .osc_lock);
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		div <= div + 2'h1;
	end
	task chk(input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		q = hrdata;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task feed;
		xfer(1'b1, 8'h08, 32'hAA);
		xfer(1'b1, 8'h08, 32'h55);
	endtask
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 4000 && s !== 1'b1; i++) @(posedge clk);
		chk({31'h0, s}, 32'h1);
	endtask
	task t_count;
		xfer(1'b1, 8'h04, 32'h10);
		rd(8'h04, 32'hFF);
		xfer(1'b1, 8'h10, 32'h80);
		xfer(1'b1, 8'h1C, 32'h3);
		xfer(1'b1, 8'h00, 32'h3);
		feed;
		xfer(1'b0, 8'h0C, 32'h0);
		t0 = q;
		repeat (253) @(posedge clk);
		xfer(1'b0, 8'h0C, 32'h0);
		chk(t0 - q, 32'h10);
	endtask
	task t_timeout;
		wait_hi(irq);
		rd(8'h18, 32'h2);
		wait_hi(chip_reset_req);
		rd(8'h18, 32'h3);
		xfer(1'b1, 8'h18, 32'h1);
		rd(8'h18, 32'h2);
		xfer(1'b1, 8'h18, 32'h2);
		rd(8'h18, 32'h0);
	endtask
	task t_modes;
		xfer(1'b1, 8'h00, 32'h8);
		rd(8'h00, 32'h9);
		xfer(1'b1, 8'h14, 32'h10);
		feed;
		rd(8'h18, 32'h1);
		rd(8'h08, 32'h0);
	endtask
	task t_prot;
		xfer(1'b1, 8'h00, 32'h4);
		xfer(1'b1, 8'h18, 32'h3);
		xfer(1'b1, 8'h04, 32'h100);
		rd(8'h18, 32'h1);
		rd(8'h04, 32'hFF);
		xfer(1'b1, 8'h14, 32'hFF_FFFF);
		feed;
		rd(8'h0C, 32'hFF);
		rd(8'h18, 32'h1);
	endtask
	task results;
		if (bad_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_count;
		t_timeout;
		t_modes;
		t_prot;
		results;
	end
	initial begin
		#300000;
		bad_count++;
		results;
	end
endmodule

// ===== wwdt_asserts.sv
`timescale 1ns/1ps
`include "wwdt_consts.svh"
module wwdt_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic irq,
	input wire logic chip_reset_req,
	input wire logic osc_lock
);
	logic rd, wr;
	assign rd = htrans[1] && hsel && hready && !hwrite;
	assign wr = htrans[1] && hsel && hready && hwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence feed_rd_s;
		rd && haddr[7:0] == `WWDT_OFS_FEED;
	endsequence
	a_no_wait: assert property (hreadyout) else $error("wait");
	a_resp_okay: assert property (!hresp) else $error("resp");
	a_rdata_idle: assert property (!$past(rd) |-> hrdata == 32'h0) else $error("rdata");
	a_feed_reads_zero: assert property (feed_rd_s |=> hrdata == 32'h0) else $error("feed");
	a_reset_pulse: assert property (chip_reset_req |=> !chip_reset_req) else $error("pulse");
	a_lock_holds: assert property (osc_lock |=> osc_lock) else $error("unlock");
	a_lock_by_write: assert property ($rose(osc_lock) |-> $past(wr, 2) || $past(wr, 3)) else $error("lock");
	a_irq_clear_write: assert property ($fell(irq) |-> $past(wr, 2) || $past(wr, 3)) else $error("irq");
endmodule
bind windowed_watchdog wwdt_asserts wwdt_asserts_inst (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata, .irq, .chip_reset_req, .osc_lock);

// ===== wwdt_consts.svh
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

// register byte offsets on the AHB-Lite slave
`define WWDT_OFS_MODE 8'h00
`define WWDT_OFS_RELOAD 8'h04
`define WWDT_OFS_FEED 8'h08
`define WWDT_OFS_COUNT 8'h0C
`define WWDT_OFS_WARN 8'h10
`define WWDT_OFS_WIN 8'h14
`define WWDT_OFS_STAT 8'h18
`define WWDT_OFS_MASK 8'h1C

// mode_register fields
`define WWDT_MODE_EN 0
`define WWDT_MODE_RST 1
`define WWDT_MODE_PROT 2
`define WWDT_MODE_LOCK 3

// status and mask fields
`define WWDT_STAT_TOF 0
`define WWDT_STAT_WARN 1

`define WWDT_CNT_W 24
`define WWDT_RELOAD_MIN 24'h00_00FF
`define WWDT_RELOAD_RST 24'hFF_FFFF
`define WWDT_WIN_RST 24'hFF_FFFF
`define WWDT_WARN_RST 24'h00_0000
`define WWDT_CNT_ZERO 24'h00_0000
`define WWDT_CNT_ONE 24'h00_0001

// prescale: four tick clock periods per decrement, last phase is 3
`define WWDT_PRE_LAST 2'h3
`define WWDT_PRE_ONE 2'h1

`endif

// ===== wwdt_pkg.sv
`include "wwdt_consts.svh"

package wwdt_pkg;

	typedef enum logic [0:0] {
		FEED_IDLE = 1'b0,
		FEED_ARMED = 1'b1
	} feed_state_e;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic en;
		logic rst_en;
		logic prot;
		logic lock;
		logic running;
		logic [`WWDT_CNT_W-1:0] reload;
		logic [`WWDT_CNT_W-1:0] cnt;
		logic [`WWDT_CNT_W-1:0] win;
		logic [`WWDT_CNT_W-1:0] warn;
		logic [1:0] stat;
		logic [1:0] mask;
		logic [1:0] pre;
		logic tick_d;
		logic warn_pend;
		feed_state_e feed;
		logic irq;
		logic chip_rst;
	} state_s;

endpackage
